// ==== rtl/iopmc_consts.svh ====
// constants for the i/o port and miscellaneous control block
`ifndef IOPMC_CONSTS_SVH
`define IOPMC_CONSTS_SVH
`define IOPMC_ADDR_W 16
`define IOPMC_OFF_PORT_A 16'h0000
`define IOPMC_OFF_PORT_B 16'h0001
`define IOPMC_OFF_PORT_C 16'h0002
`define IOPMC_OFF_PORT_D 16'h0003
`define IOPMC_OFF_DIR_A 16'h0004
`define IOPMC_OFF_DIR_B 16'h0005
`define IOPMC_OFF_DIR_C 16'h0006
`define IOPMC_OFF_EECLK 16'h0007
`define IOPMC_OFF_MISC 16'h000c
`define IOPMC_OFF_WOI_EN 16'h0040
`define IOPMC_MISC_POR 7
`define IOPMC_MISC_RISE 6
`define IOPMC_MISC_FALL 5
`define IOPMC_MISC_EXT_IRQ_ENABLE 4
`define IOPMC_MISC_SFA 3
`define IOPMC_MISC_SFB 2
`define IOPMC_MISC_SM 1
`define IOPMC_MISC_WATCHDOG_ENABLE 0
`define IOPMC_EECLK_CLKOUT 3
`define IOPMC_EECLK_MASK 8'h0f
`define IOPMC_DIR_RESET 8'h00
`define IOPMC_PORTC_CLK_PIN 2
`define IOPMC_PERIOD_SLOW 13'h1000
`define IOPMC_PERIOD_FAST 13'h0100
`define IOPMC_BUS_DIV_NORMAL 6'h02
`define IOPMC_BUS_DIV_SLOW 6'h20
`endif

// ==== rtl/iopmc_pkg.sv ====
// types for the i/o port and miscellaneous control block
package iopmc_pkg;
   typedef logic [7:0] iopmc_byte_t;
   typedef logic [15:0] iopmc_addr_t;
   typedef struct packed {
      iopmc_byte_t dir_a;
      iopmc_byte_t dir_b;
      iopmc_byte_t dir_c;
      iopmc_byte_t lat_a;
      iopmc_byte_t lat_b;
      iopmc_byte_t lat_c;
      logic clk_out_en;
      logic [2:0] eeprom_bits;
      iopmc_byte_t misc;
      logic woi_en;
      logic [1:0] irq_sync;
      iopmc_byte_t woi_sync0;
      iopmc_byte_t woi_sync1;
      iopmc_byte_t pd_sync0;
      iopmc_byte_t pd_sync1;
      iopmc_byte_t pa_sync0;
      iopmc_byte_t pa_sync1;
      iopmc_byte_t pc_sync0;
      iopmc_byte_t pc_sync1;
      logic irq_prev;
      logic woi_prev;
      logic irq_event;
      iopmc_byte_t rdata;
      logic clk_div;
   } iopmc_state_t;
endpackage : iopmc_pkg

// ==== rtl/iopmc_top.sv ====
// i/o ports a-d, direction control on ports a-c, clock output and miscellaneous register
`timescale 1ns/1ns
`include "iopmc_consts.svh"

module iopmc_top import iopmc_pkg::*; #(
   parameter logic WATCHDOG_ENABLE_OPTION = 1'b0,
   parameter logic PULLDOWN_B_OPTION = 1'b0,
   parameter logic PULLDOWN_C_OPTION = 1'b0
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic power_on_reset,
   // register port
   input wire iopmc_pkg::iopmc_addr_t reg_addr,
   input wire iopmc_pkg::iopmc_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output iopmc_pkg::iopmc_byte_t reg_rdata,
   // cpu side status
   input wire logic cpu_irq_mask,
   input wire logic stop_entry,
   input wire logic internal_bus_clock,
   output logic ext_irq,
   output logic watchdog_clear,
   output logic watchdog_enable,
   output logic bus_slow_mode,
   output logic [5:0] bus_clock_divide,
   output logic [12:0] pulse_length_chan_a_period,
   output logic [12:0] pulse_length_chan_b_period,
   // pins
   input wire logic irq_pin_b,
   input wire iopmc_pkg::iopmc_byte_t port_a_in,
   output iopmc_pkg::iopmc_byte_t port_a_out,
   output iopmc_pkg::iopmc_byte_t port_a_oe,
   input wire iopmc_pkg::iopmc_byte_t port_b_in,
   output iopmc_pkg::iopmc_byte_t port_b_out,
   output iopmc_pkg::iopmc_byte_t port_b_oe,
   output iopmc_pkg::iopmc_byte_t port_b_pulldown,
   input wire iopmc_pkg::iopmc_byte_t port_c_in,
   output iopmc_pkg::iopmc_byte_t port_c_out,
   output iopmc_pkg::iopmc_byte_t port_c_oe,
   output iopmc_pkg::iopmc_byte_t port_c_pulldown,
   input wire iopmc_pkg::iopmc_byte_t port_d_in
);
   import iopmc_pkg::*;

   // ==========================================
   // helpers
   function automatic iopmc_byte_t pin_or_latch(input iopmc_byte_t dir, input iopmc_byte_t lat,
                                                input iopmc_byte_t pin);
      pin_or_latch = (dir & lat) | (~dir & pin);
   endfunction : pin_or_latch

   iopmc_state_t s_q;
   iopmc_state_t s_d;
   iopmc_byte_t dir_c_eff;
   logic irq_low;
   logic woi_hi;
   logic rise_sel;
   logic fall_sel;

   // ==========================================
   // pin view
   always_comb begin
      dir_c_eff = s_q.dir_c;
      if (s_q.clk_out_en) begin
         dir_c_eff[`IOPMC_PORTC_CLK_PIN] = 1'b1;
      end
   end

   assign rise_sel = s_q.misc[`IOPMC_MISC_RISE];
   assign fall_sel = s_q.misc[`IOPMC_MISC_FALL];
   // low level on the synchronised irq pin, or, with woi_en set, any high input pin on port b
   assign irq_low = ~s_q.irq_sync[1];
   assign woi_hi = s_q.woi_en & (|(s_q.woi_sync1 & ~s_q.dir_b));

   // ==========================================
   // next state
   always_comb begin
      logic wr_ok;
      logic irq_edge;
      logic woi_edge;
      wr_ok = 1'b0;
      irq_edge = 1'b0;
      woi_edge = 1'b0;
      s_d = s_q;
      // two-flop synchronisers
      s_d.irq_sync = {s_q.irq_sync[0], irq_pin_b};
      s_d.woi_sync0 = port_b_in;
      s_d.woi_sync1 = s_q.woi_sync0;
      s_d.pa_sync0 = port_a_in;
      s_d.pa_sync1 = s_q.pa_sync0;
      s_d.pc_sync0 = port_c_in;
      s_d.pc_sync1 = s_q.pc_sync0;
      s_d.pd_sync0 = port_d_in;
      s_d.pd_sync1 = s_q.pd_sync0;
      s_d.irq_prev = irq_low;
      s_d.woi_prev = woi_hi;
      // sensitivity: irq pin active low, wired-or uses opposite polarity
      case ({rise_sel, fall_sel})
         2'b00: begin
            irq_edge = irq_low;
            woi_edge = woi_hi;
         end
         2'b01: begin
            irq_edge = irq_low & ~s_q.irq_prev;
            woi_edge = woi_hi & ~s_q.woi_prev;
         end
         2'b10: begin
            irq_edge = ~irq_low & s_q.irq_prev;
            woi_edge = ~woi_hi & s_q.woi_prev;
         end
         default: begin
            irq_edge = irq_low ^ s_q.irq_prev;
            woi_edge = woi_hi ^ s_q.woi_prev;
         end
      endcase
      s_d.irq_event = s_q.misc[`IOPMC_MISC_EXT_IRQ_ENABLE] & (irq_edge | woi_edge);
      // register writes
      if (reg_wr) begin
         case (reg_addr)
            `IOPMC_OFF_PORT_A: s_d.lat_a = reg_wdata;
            `IOPMC_OFF_PORT_B: s_d.lat_b = reg_wdata;
            `IOPMC_OFF_PORT_C: s_d.lat_c = reg_wdata;
            `IOPMC_OFF_DIR_A: s_d.dir_a = reg_wdata;
            `IOPMC_OFF_DIR_B: s_d.dir_b = reg_wdata;
            `IOPMC_OFF_DIR_C: s_d.dir_c = reg_wdata;
            `IOPMC_OFF_EECLK: begin
               s_d.clk_out_en = reg_wdata[`IOPMC_EECLK_CLKOUT];
               s_d.eeprom_bits = reg_wdata[2:0];
            end
            `IOPMC_OFF_WOI_EN: s_d.woi_en = reg_wdata[0];
            `IOPMC_OFF_MISC: begin
               wr_ok = cpu_irq_mask;
               // only a zero reaches the flag; software cannot set it
               if (!reg_wdata[`IOPMC_MISC_POR]) begin
                  s_d.misc[`IOPMC_MISC_POR] = 1'b0;
               end
               if (wr_ok) begin
                  s_d.misc[`IOPMC_MISC_RISE] = reg_wdata[`IOPMC_MISC_RISE];
                  s_d.misc[`IOPMC_MISC_FALL] = reg_wdata[`IOPMC_MISC_FALL];
                  s_d.misc[`IOPMC_MISC_EXT_IRQ_ENABLE] = reg_wdata[`IOPMC_MISC_EXT_IRQ_ENABLE];
               end
               s_d.misc[`IOPMC_MISC_SFA] = reg_wdata[`IOPMC_MISC_SFA];
               s_d.misc[`IOPMC_MISC_SFB] = reg_wdata[`IOPMC_MISC_SFB];
               s_d.misc[`IOPMC_MISC_SM] = reg_wdata[`IOPMC_MISC_SM];
               if (reg_wdata[`IOPMC_MISC_WATCHDOG_ENABLE]) begin
                  s_d.misc[`IOPMC_MISC_WATCHDOG_ENABLE] = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // stop wins over a same-cycle write of slow mode
      if (stop_entry) begin
         s_d.misc[`IOPMC_MISC_SM] = 1'b0;
      end
      // read data, one cycle after the strobe
      s_d.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            `IOPMC_OFF_PORT_A: s_d.rdata = pin_or_latch(s_q.dir_a, s_q.lat_a, s_q.pa_sync1);
            `IOPMC_OFF_PORT_B: s_d.rdata = pin_or_latch(s_q.dir_b, s_q.lat_b, s_q.woi_sync1);
            `IOPMC_OFF_PORT_C: s_d.rdata = pin_or_latch(dir_c_eff, s_q.lat_c, s_q.pc_sync1);
            `IOPMC_OFF_PORT_D: s_d.rdata = s_q.pd_sync1;
            `IOPMC_OFF_DIR_A: s_d.rdata = s_q.dir_a;
            `IOPMC_OFF_DIR_B: s_d.rdata = s_q.dir_b;
            `IOPMC_OFF_DIR_C: s_d.rdata = s_q.dir_c;
            `IOPMC_OFF_EECLK: s_d.rdata = {4'h0, s_q.clk_out_en, s_q.eeprom_bits} & `IOPMC_EECLK_MASK;
            `IOPMC_OFF_MISC: s_d.rdata = s_q.misc;
            `IOPMC_OFF_WOI_EN: s_d.rdata = {7'h00, s_q.woi_en};
            default: s_d.rdata = 8'h00;
         endcase
      end
      // power-on sets the flag; external reset leaves it alone
      if (power_on_reset) begin
         s_d.misc[`IOPMC_MISC_POR] = 1'b1;
      end
   end

   // ==========================================
   // state register; latches keep their value through reset
   always_ff @(posedge core_clk) begin
      s_q <= s_d;
      if (!rst_b) begin
         s_q.dir_a <= `IOPMC_DIR_RESET;
         s_q.dir_b <= `IOPMC_DIR_RESET;
         s_q.dir_c <= `IOPMC_DIR_RESET;
         s_q.clk_out_en <= 1'b0;
         s_q.eeprom_bits <= 3'h0;
         s_q.woi_en <= 1'b0;
         s_q.misc[6:1] <= 6'h08;
         s_q.misc[`IOPMC_MISC_WATCHDOG_ENABLE] <= WATCHDOG_ENABLE_OPTION;
         s_q.misc[`IOPMC_MISC_POR] <= power_on_reset | s_q.misc[`IOPMC_MISC_POR];
         s_q.irq_sync <= 2'b11;
         s_q.irq_prev <= 1'b0;
         s_q.woi_prev <= 1'b0;
         s_q.irq_event <= 1'b0;
         s_q.rdata <= 8'h00;
         s_q.clk_div <= 1'b0;
      end
   end

   // ==========================================
   // outputs
   assign reg_rdata = s_q.rdata;
   assign ext_irq = s_q.irq_event;
   // pulse when software writes one to the watchdog bit
   assign watchdog_clear = reg_wr & (reg_addr == `IOPMC_OFF_MISC) & reg_wdata[`IOPMC_MISC_WATCHDOG_ENABLE];
   assign watchdog_enable = s_q.misc[`IOPMC_MISC_WATCHDOG_ENABLE];
   assign bus_slow_mode = s_q.misc[`IOPMC_MISC_SM];
   assign bus_clock_divide = s_q.misc[`IOPMC_MISC_SM] ? `IOPMC_BUS_DIV_SLOW : `IOPMC_BUS_DIV_NORMAL;
   assign pulse_length_chan_a_period = s_q.misc[`IOPMC_MISC_SFA] ? `IOPMC_PERIOD_SLOW : `IOPMC_PERIOD_FAST;
   assign pulse_length_chan_b_period = s_q.misc[`IOPMC_MISC_SFB] ? `IOPMC_PERIOD_SLOW : `IOPMC_PERIOD_FAST;
   assign port_a_out = s_q.lat_a;
   assign port_a_oe = s_q.dir_a;
   assign port_b_out = s_q.lat_b;
   assign port_b_oe = s_q.dir_b;
   assign port_b_pulldown = PULLDOWN_B_OPTION ? ~s_q.dir_b : 8'h00;
   assign port_c_oe = dir_c_eff;
   assign port_c_pulldown = PULLDOWN_C_OPTION ? ~dir_c_eff : 8'h00;
   // clock is a pass-through of the internal bus clock, glitch-free only if that clock is
   always_comb begin
      port_c_out = s_q.lat_c;
      if (s_q.clk_out_en) begin
         port_c_out[`IOPMC_PORTC_CLK_PIN] = internal_bus_clock;
      end
   end

   // ==========================================
   // checks
   // reset values of directions a and b and control bits; the port latches are left alone
   dir_reset_a: assert property (@(posedge core_clk) !rst_b |=> (port_a_oe == 8'h00 && port_b_oe == 8'h00))
      else $error("direction not cleared by reset");

   ctrl_reset_a: assert property (@(posedge core_clk) !rst_b |=>
      !s_q.clk_out_en && !bus_slow_mode && s_q.misc[6:4] == 3'b001)
      else $error("control bits not at reset value");

   watchdog_enable_reset_a: assert property (@(posedge core_clk) !rst_b |=> watchdog_enable == WATCHDOG_ENABLE_OPTION)
      else $error("watchdog bit not at option value");

   por_set_a: assert property (@(posedge core_clk) power_on_reset |=> s_q.misc[`IOPMC_MISC_POR])
      else $error("power-on flag not set");

   // a written zero clears the flag unless power-on holds it up in the same cycle
   por_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_MISC && !reg_wdata[`IOPMC_MISC_POR] && !power_on_reset) |=>
      !s_q.misc[`IOPMC_MISC_POR])
      else $error("power-on flag not cleared");

   sens_lock_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_MISC && !cpu_irq_mask) |=> $stable(s_q.misc[6:4]))
      else $error("sensitivity changed without mask");

   sens_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_MISC && cpu_irq_mask) |=> s_q.misc[6:4] == $past(reg_wdata[6:4]))
      else $error("sensitivity write lost with mask set");

   watchdog_enable_keep_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $past(watchdog_enable) |-> watchdog_enable)
      else $error("watchdog disabled by software");

   watchdog_enable_clear_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      watchdog_clear |=> watchdog_enable)
      else $error("watchdog not enabled by a written one");

   slow_stop_a: assert property (@(posedge core_clk) disable iff (!rst_b) stop_entry |=> !bus_slow_mode)
      else $error("slow mode kept across stop");

   // stop has priority, so only writes outside a stop cycle are followed
   slow_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_MISC && !stop_entry) |=>
      bus_slow_mode == $past(reg_wdata[`IOPMC_MISC_SM]))
      else $error("slow mode write lost");

   irq_off_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      !s_q.misc[`IOPMC_MISC_EXT_IRQ_ENABLE] |=> !ext_irq)
      else $error("interrupt raised while disabled");

   dir_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_DIR_A) |=> port_a_oe == $past(reg_wdata))
      else $error("direction write lost");

   latch_write_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_PORT_A) |=> port_a_out == $past(reg_wdata))
      else $error("latch write lost");

   // read data stands for exactly one cycle, idle zero otherwise
   rd_idle_a: assert property (@(posedge core_clk) !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside its cycle");

   clk_dir_a: assert property (@(posedge core_clk) s_q.clk_out_en |-> port_c_oe[2])
      else $error("clock pin not output");

   clk_pass_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      s_q.clk_out_en |-> port_c_out[`IOPMC_PORTC_CLK_PIN] == internal_bus_clock)
      else $error("clock not on pin c2");

   pull_in_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (port_b_pulldown & port_b_oe) == 8'h00 && (port_c_pulldown & port_c_oe) == 8'h00)
      else $error("pull-down on an output pin");

   upper_zero_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == `IOPMC_OFF_EECLK) |=> reg_rdata[7:4] == 4'h0)
      else $error("upper clock-control bits nonzero");

   // period follows the mode bit as written; stop and the mask never touch it
   period_sel_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_MISC) |=>
      pulse_length_chan_a_period == ($past(reg_wdata[`IOPMC_MISC_SFA]) ? 13'h1000 : 13'h0100))
      else $error("wrong period for channel a");

   period_b_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == `IOPMC_OFF_MISC) |=>
      pulse_length_chan_b_period == ($past(reg_wdata[`IOPMC_MISC_SFB]) ? 13'h1000 : 13'h0100))
      else $error("wrong period for channel b");

   woi_irq_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (woi_hi && s_q.misc[4] && s_q.misc[6:5] == 2'b00) |=> ext_irq)
      else $error("wired-or level missed");
endmodule : iopmc_top

// ==== verification/iopmc_pins.sv ====
// board model behind ports a, b and c
`timescale 1ns/1ns
module iopmc_pins import iopmc_pkg::*; (
   // design side
   input wire iopmc_pkg::iopmc_byte_t a_out,
   input wire iopmc_pkg::iopmc_byte_t a_oe,
   input wire iopmc_pkg::iopmc_byte_t b_out,
   input wire iopmc_pkg::iopmc_byte_t b_oe,
   input wire iopmc_pkg::iopmc_byte_t b_pd,
   input wire iopmc_pkg::iopmc_byte_t c_out,
   input wire iopmc_pkg::iopmc_byte_t c_oe,
   // board drive on undriven pins
   input wire iopmc_pkg::iopmc_byte_t ext_a,
   input wire iopmc_pkg::iopmc_byte_t ext_b,
   input wire iopmc_pkg::iopmc_byte_t ext_c,
   // resolved pin levels
   output iopmc_pkg::iopmc_byte_t a_in,
   output iopmc_pkg::iopmc_byte_t b_in,
   output iopmc_pkg::iopmc_byte_t c_in
);
   import iopmc_pkg::*;
   // ==========================================
   // pin resolution
   // a driving device wins; on port b the board only pulls high, so an open pin
   // settles at its pull-down or, without one, floats high
   assign a_in = (a_oe & a_out) | (~a_oe & ext_a);
   assign b_in = (b_oe & b_out) | (~b_oe & (ext_b | ~b_pd));
   assign c_in = (c_oe & c_out) | (~c_oe & ext_c);
endmodule : iopmc_pins

// ==== verification/tb.sv ====
// self-checking bench for the i/o port and miscellaneous control block
`timescale 1ns/1ns
`include "iopmc_consts.svh"
module tb;
   import iopmc_pkg::*;
   logic core_clk, rst_b, power_on_reset, reg_wr, reg_rd, cpu_irq_mask, stop_entry, internal_bus_clock, irq_pin_b;
   logic ext_irq, watchdog_clear, watchdog_enable, bus_slow_mode, last_wdc;
   logic [5:0] bus_clock_divide;
   logic [12:0] pulse_length_chan_a_period, pulse_length_chan_b_period;
   iopmc_addr_t reg_addr;
   iopmc_byte_t reg_wdata, reg_rdata, rd_v, port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe;
   iopmc_byte_t port_b_pulldown, port_c_in, port_c_out, port_c_oe, port_c_pulldown, port_d_in, ext_a, ext_b, ext_c;
   int n_fail, n_checks, c;
   int ef[4] = '{0, 1, 0, 1};
   int er[4] = '{0, 0, 1, 1};
   iopmc_top #(.PULLDOWN_B_OPTION(1'b1)) u_dut (.*);
   iopmc_pins u_pins (.a_out(port_a_out), .a_oe(port_a_oe), .b_out(port_b_out), .b_oe(port_b_oe),
      .b_pd(port_b_pulldown), .c_out(port_c_out), .c_oe(port_c_oe), .ext_a(ext_a), .ext_b(ext_b),
      .ext_c(ext_c), .a_in(port_a_in), .b_in(port_b_in), .c_in(port_c_in));
   // ==========================================
   // tasks
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic wr(input iopmc_addr_t a, input iopmc_byte_t d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      #1 last_wdc = watchdog_clear;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input iopmc_addr_t a);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
   endtask : rd
   // ext_irq cycles seen over n edges
   task automatic cnt(input int n);
      c = 0;
      repeat (n) begin
         @(posedge core_clk);
         #1 if (ext_irq === 1'b1) c++;
      end
   endtask : cnt
   task automatic pin(input logic v);
      @(posedge core_clk);
      irq_pin_b <= v;
   endtask : pin
   task automatic do_reset(input logic por);
      @(posedge core_clk);
      rst_b <= 1'b0;
      power_on_reset <= por;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      power_on_reset <= 1'b0;
      #1;
   endtask : do_reset
   // ==========================================
   // clock, watchdog, tests
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #20000;
      n_fail++;
      finish_test();
   end
   initial begin
      {rst_b, power_on_reset, reg_wr, reg_rd, cpu_irq_mask, stop_entry, internal_bus_clock} = 7'h00;
      irq_pin_b = 1'b1;
      {reg_addr, reg_wdata, port_d_in, ext_a, ext_b, ext_c} = '0;
      do_reset(1'b1);
      for (int i = 4; i < 8; i++) begin
         rd(16'(i));
         chk("reset reg", 16'h0000, rd_v);
      end
      rd(`IOPMC_OFF_MISC);
      chk("misc reset", 16'h0090, rd_v);
      rd(16'h0010);
      chk("unmapped", 16'h0000, rd_v);
      $display("test reset done");
      wr(`IOPMC_OFF_PORT_A, 8'h5a);
      wr(`IOPMC_OFF_DIR_A, 8'h0f);
      ext_a <= 8'hc3;
      port_d_in <= 8'h96;
      repeat (4) @(posedge core_clk);
      chk("dir a oe", 16'h000f, port_a_oe);
      rd(`IOPMC_OFF_PORT_A);
      chk("port a mix", 16'h00ca, rd_v);
      rd(`IOPMC_OFF_PORT_D);
      chk("port d", 16'h0096, rd_v);
      $display("test ports done");
      wr(`IOPMC_OFF_MISC, 8'h6e);
      rd(`IOPMC_OFF_MISC);
      chk("misc masked", 16'h001e, rd_v);
      chk("period a", 16'h1000, pulse_length_chan_a_period);
      chk("period b", 16'h1000, pulse_length_chan_b_period);
      chk("divide slow", 16'h0020, bus_clock_divide);
      chk("slow mode on", 16'h0001, bus_slow_mode);
      @(posedge core_clk);
      stop_entry <= 1'b1;
      @(posedge core_clk);
      stop_entry <= 1'b0;
      rd(`IOPMC_OFF_MISC);
      chk("stop clears slow", 16'h001c, rd_v);
      chk("divide normal", 16'h0002, bus_clock_divide);
      chk("slow mode off", 16'h0000, bus_slow_mode);
      cpu_irq_mask <= 1'b1;
      wr(`IOPMC_OFF_MISC, 8'h60);
      rd(`IOPMC_OFF_MISC);
      chk("misc unmasked", 16'h0060, rd_v);
      chk("period fast", 16'h0100, pulse_length_chan_a_period);
      chk("period b fast", 16'h0100, pulse_length_chan_b_period);
      wr(`IOPMC_OFF_MISC, 8'h01);
      chk("watchdog_enable clear", 16'h0001, last_wdc);
      wr(`IOPMC_OFF_MISC, 8'h00);
      chk("watchdog_enable no clear", 16'h0000, last_wdc);
      chk("watchdog_enable stays", 16'h0001, watchdog_enable);
      $display("test misc done");
      // sensitivity table, each mode entered with the pin idle high
      for (int m = 0; m < 4; m++) begin
         wr(`IOPMC_OFF_MISC, {1'b0, 2'(m), 1'b1, 4'h0});
         pin(1'b0);
         cnt(8);
         chk("irq fall", (m == 0) ? 16'h0001 : 16'(ef[m]), (m == 0) ? 16'(c > 2) : 16'(c));
         pin(1'b1);
         cnt(8);
         if (m != 0) chk("irq rise", 16'(er[m]), 16'(c));
      end
      wr(`IOPMC_OFF_MISC, 8'h20);
      pin(1'b0);
      cnt(8);
      chk("irq disabled", 16'h0000, 16'(c));
      pin(1'b1);
      wr(`IOPMC_OFF_MISC, 8'h10);
      wr(`IOPMC_OFF_WOI_EN, 8'h01);
      ext_b <= 8'h01;
      cnt(8);
      chk("woi level", 16'h0001, 16'(c > 2));
      wr(`IOPMC_OFF_PORT_B, 8'h00);
      wr(`IOPMC_OFF_DIR_B, 8'h01);
      chk("pulldown", 16'h00fe, port_b_pulldown);
      chk("port b oe", 16'h0001, port_b_oe);
      chk("port b latch", 16'h0000, port_b_out);
      repeat (4) @(posedge core_clk);
      cnt(8);
      chk("woi output pin", 16'h0000, 16'(c));
      $display("test irq done");
      wr(`IOPMC_OFF_PORT_C, 8'h00);
      wr(`IOPMC_OFF_EECLK, 8'hff);
      ext_c <= 8'hff;
      rd(`IOPMC_OFF_EECLK);
      chk("eeclk upper", 16'h000f, rd_v);
      chk("c2 forced out", 16'h0004, port_c_oe);
      internal_bus_clock <= 1'b1;
      rd(`IOPMC_OFF_PORT_C);
      chk("c2 reads latch", 16'h00fb, rd_v);
      chk("c2 clock high", 16'h0001, port_c_out[2]);
      internal_bus_clock <= 1'b0;
      #1 chk("c2 clock low", 16'h0000, port_c_out[2]);
      chk("c pulldown off", 16'h0000, port_c_pulldown);
      $display("test clock out done");
      do_reset(1'b0);
      chk("latch kept", 16'h005a, port_a_out);
      chk("oe cleared", 16'h0000, port_a_oe);
      rd(`IOPMC_OFF_MISC);
      chk("misc ext reset", 16'h0010, rd_v);
      rd(`IOPMC_OFF_EECLK);
      chk("eeclk reset", 16'h0000, rd_v);
      $display("test second reset done");
      finish_test();
   end
endmodule : tb
